// ===== verif/modem_control_loopback_tb.sv
/*
  Self-checking bench for the modem control and loopback block.
  Assumes the one-cycle registered Wishbone ack and a peer modem on the pins.
*/
module modem_control_loopback_tb
  import mcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, bus16 = 1, utx = 1;
  logic rxe = 0, txe = 0, carrier_req = 0, ring_req = 0, rx_req = 1;
  logic [3:0] adr = 4'h0, ms_n;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic ack, tx_pin, cts_n, dsr_n, carrier_n, ring_n, rts_n, dtr_n;
  logic rx_pin, urx, int_o, int_oe, irq;
  int mismatches = 0, compares = 0;
  always #50 clk = ~clk;
  modem_control_loopback dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .bus16_mode(bus16), .rx_pin(rx_pin), .tx_pin(tx_pin), .cts_n_pin(cts_n),
    .dsr_n_pin(dsr_n), .carrier_detect_n(carrier_n), .ring_ind_n(ring_n), .rts_n(rts_n),
    .dtr_n(dtr_n), .uart_tx_data(utx), .uart_rx_data(urx), .modem_status_n(ms_n),
    .rx_event(rxe), .tx_event(txe), .int_o(int_o), .int_oe(int_oe), .irq(irq));
  modem_peer peer (.rts_n(rts_n), .dtr_n(dtr_n), .carrier_req(carrier_req),
    .ring_req(ring_req), .rx_req(rx_req), .cts_n_pin(cts_n), .dsr_n_pin(dsr_n),
    .carrier_detect_n(carrier_n), .ring_ind_n(ring_n), .rx_pin(rx_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic Wishbone cycle; entered just after a rising edge.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
    rd = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  // Holds an event input high for one cycle and lets the status settle.
  task automatic pulse(input logic rx);
    if (rx) rxe <= 1; else txe <= 1;
    @(posedge clk);
    rxe <= 0; txe <= 0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, an unmapped read and normal pass-through.
  task automatic t_reset;
    wb(0, OFS_CTRL, 0); chk("ctrl", rd, 32'h0);
    wb(0, 4'h2, 0); chk("unmapped", rd, 32'h0);
    chk("rts_n", rts_n, 1); chk("dtr_n", dtr_n, 1);
    utx <= 0; @(posedge clk); @(posedge clk);
    chk("tx_pin", tx_pin, 0);
    utx <= 1;
  endtask
  // Every request and ready combination, then pin inputs in normal mode.
  task automatic t_pins;
    for (int i = 0; i < 4; i++) begin
      wb(1, OFS_CTRL, 32'(i));
      chk("rts_n", rts_n, 32'(i[1] == 0));
      chk("dtr_n", dtr_n, 32'(i[0] == 0));
    end
    rx_req <= 0; repeat (3) @(posedge clk);
    chk("modem_n", ms_n, 4'hC);
    chk("rx", urx, 0);
    rx_req <= 1;
  endtask
  // Loopback cuts the pins and sources modem status from the low bits.
  task automatic t_loop;
    wb(1, OFS_ENA, 32'hF); wb(1, OFS_MSK, 32'hF); wb(0, OFS_STS, 0);
    wb(1, OFS_CTRL, 32'h1D);
    chk("rts_n", rts_n, 1); chk("dtr_n", dtr_n, 1); chk("tx", tx_pin, 1);
    chk("modem_n", ms_n, 4'h1);
    carrier_req <= 1; ring_req <= 1; rx_req <= 0; utx <= 0; repeat (3) @(posedge clk);
    chk("modem_n", ms_n, 4'h1); chk("tx", tx_pin, 1);
    chk("rx", urx, 0);
    utx <= 1; carrier_req <= 0; ring_req <= 0; rx_req <= 1;
    chk("irq", irq, 1);
    wb(0, OFS_STS, 0); chk("sts", rd, 32'hC);
    chk("irq", irq, 0);
    wb(1, OFS_CTRL, 32'h15); chk("modem_n", ms_n, 4'h9);
    wb(0, OFS_STS, 0); chk("sts", rd, 32'h4);
  endtask
  // Events, mask, enable gating and interrupt pin styles in loopback.
  task automatic t_events;
    pulse(1);
    chk("oe", int_oe, 1); chk("o", int_o, 1);
    wb(1, OFS_CTRL, 32'h35); chk("oe", int_oe, 1);
    wb(0, OFS_STS, 0); chk("sts", rd, 32'h1);
    chk("oe", int_oe, 0);
    wb(1, OFS_CTRL, 32'h15); chk("oe", int_oe, 1); chk("o", int_o, 0);
    bus16 <= 0; pulse(0); @(posedge clk);
    chk("oe", int_oe, 1); chk("o", int_o, 0);
    wb(1, OFS_CTRL, 32'h35); chk("o", int_o, 0);
    wb(1, OFS_MSK, 32'h0); chk("irq", irq, 0); chk("oe", int_oe, 0);
    wb(1, OFS_MSK, 32'hF); wb(0, OFS_STS, 0); chk("sts", rd, 32'h2);
    wb(1, OFS_ENA, 32'h0); pulse(1); pulse(0);
    wb(0, OFS_STS, 0); chk("sts", rd, 32'h0);
    bus16 <= 1;
  endtask
  // Clearing the loopback bit gives the pins back.
  task automatic t_exit;
    wb(1, OFS_CTRL, 32'h03);
    chk("rts_n", rts_n, 0); chk("dtr_n", dtr_n, 0);
    carrier_req <= 1; repeat (3) @(posedge clk);
    chk("modem_n", ms_n, 4'h4); carrier_req <= 0;
    rx_req <= 0; repeat (3) @(posedge clk);
    chk("rx", urx, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 8 cycles, then each scenario in turn.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_reset();
    t_pins();
    t_loop();
    t_events();
    t_exit();
    wrap_up();
  end
endmodule

// ===== verif/modem_peer.sv
/*
  Behavioural modem on the far side of the modem pins.
  Assumes the bench steers carrier, ring and serial data; the handshake pins answer at once.
*/
module modem_peer (
  input wire logic rts_n, // Request-to-send from the block.
  input wire logic dtr_n, // Terminal-ready from the block.
  input wire logic carrier_req, // Bench wish: carrier present.
  input wire logic ring_req, // Bench wish: ring present.
  input wire logic rx_req, // Bench wish: serial line level.
  output logic cts_n_pin, // Clear-to-send answer, active low.
  output logic dsr_n_pin, // Data-set-ready answer, active low.
  output logic carrier_detect_n, // Carrier detect, active low.
  output logic ring_ind_n, // Ring indicator, active low.
  output logic rx_pin // Serial data towards the block.
);
  // The modem grants clear-to-send and ready as soon as they are asked for.
  assign cts_n_pin = rts_n;
  assign dsr_n_pin = dtr_n;
  assign carrier_detect_n = ~carrier_req;
  assign ring_ind_n = ~ring_req;
  assign rx_pin = rx_req;
endmodule

// ===== verilog/mcl_pkg.sv
/*
  Package for the modem control and loopback block.
  Holds register offsets, field positions, reset values and the interrupt source layout.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package mcl_pkg;
  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ENA = 4'h4;
  localparam logic [3:0] OFS_STS = 4'h8;
  localparam logic [3:0] OFS_MSK = 4'hC;
  // Modem control register field positions.
  localparam int CTRL_INT_TYPE = 5;
  localparam int CTRL_LOOP = 4;
  localparam int CTRL_AUX_TWO = 3;
  localparam int CTRL_AUX_ONE = 2;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_DTR = 0;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] ENA_RST = 4'h0;
  localparam logic [3:0] MSK_RST = 4'h0;
  // Interrupt source positions, shared by enable, status and mask.
  localparam int SRC_RX = 0;
  localparam int SRC_TX = 1;
  localparam int SRC_MODEM = 2;
  localparam int SRC_LOOPCHG = 3;
  // Unmapped reads return this value.
  localparam logic [31:0] RD_NONE = 32'h0000_0000;
endpackage

// ===== verilog/modem_control_loopback.sv
/*
  Modem control register with loopback routing, interrupt pin style and a
  small interrupt status block, reached over classic Wishbone.
  Assumes one 10 MHz clock, an asynchronous active-low reset, and that the
  receiver and transmitter event pulses come from logic on the same clock.
*/
// Decided for this implementation: the Wishbone register port and the address map.
// Summary of operation
// - Bit 5 picks push-pull or open-source interrupt.
// - 68 bus mode forces open-drain interrupt.
// - Bit 4 loopback cuts serial and modem pins.
// - Loopback wires modem outputs into modem inputs.
// - Receive and transmit interrupts work in loopback.
// - Loopback modem interrupts come from low bits.
// - Interrupt enable gates every source always.
// - Bit 3 feeds carrier detect, bit 2 ring.
// - Bits 1,0 drive request and ready, low active.
// - Cleared loopback bit means normal operation.
module modem_control_loopback
  import mcl_pkg::*;
(
  input wire logic clk, // Block clock, 10 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [3:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic bus16_mode, // Bus style select pin, high for 16 style.
  input wire logic rx_pin, // Serial receive pin.
  output logic tx_pin, // Serial transmit pin.
  input wire logic cts_n_pin, // Clear-to-send pin, active low.
  input wire logic dsr_n_pin, // Data-set-ready pin, active low.
  input wire logic carrier_detect_n, // Carrier detect pin, active low.
  input wire logic ring_ind_n, // Ring indicator pin, active low.
  output logic rts_n, // Request-to-send pin, active low.
  output logic dtr_n, // Terminal-ready pin, active low.
  input wire logic uart_tx_data, // Serial data from the transmitter.
  output logic uart_rx_data, // Serial data to the receiver.
  output logic [3:0] modem_status_n, // Modem inputs seen by the core: carrier, ring, dsr, cts.
  input wire logic rx_event, // Receiver interrupt event pulse.
  input wire logic tx_event, // Transmitter interrupt event pulse.
  output logic int_o, // Interrupt pin output value.
  output logic int_oe, // Interrupt pin output enable.
  output logic irq // Level interrupt to the local processor.
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode.

  logic [7:0] modem_control_reg_ff; // Modem control register.
  logic [3:0] int_enable_reg_ff; // Interrupt enable per source.
  logic [3:0] sts_ff; // Sticky interrupt status.
  logic [3:0] msk_ff; // Interrupt mask.
  logic ack_ff; // Bus acknowledge.
  logic [31:0] rdat_ff; // Read data.
  logic [3:0] pins_sync; // Synchronised carrier, ring, dsr, cts pins.
  logic rx_sync; // Synchronised receive pin.
  logic bus16_sync; // Synchronised bus style strap.
  logic [3:0] modem_prev_ff; // Previous modem status for change detect.

  wire req = wb_cyc_i && wb_stb_i && !ack_ff; // New request this cycle.
  wire wr = req && wb_we_i; // Write request.
  wire rd = req && !wb_we_i; // Read request.
  wire hit_ctrl = wb_adr_i == OFS_CTRL; // Modem control selected.
  wire hit_ena = wb_adr_i == OFS_ENA; // Enable register selected.
  wire hit_sts = wb_adr_i == OFS_STS; // Status register selected.
  wire hit_msk = wb_adr_i == OFS_MSK; // Mask register selected.
  wire wr_ctrl = wr && hit_ctrl && wb_sel_i[0]; // Modem control write.
  wire wr_ena = wr && hit_ena && wb_sel_i[0]; // Enable write.
  wire wr_msk = wr && hit_msk && wb_sel_i[0]; // Mask write.
  wire rd_sts = rd && hit_sts; // Status read, clears it.
  wire loop_on = modem_control_reg_ff[CTRL_LOOP]; // Loopback active.

  // Read multiplexer; unmapped addresses read zero.
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, modem_control_reg_ff} :
                       hit_ena ? {28'h0000000, int_enable_reg_ff} :
                       hit_sts ? {28'h0000000, sts_ff} :
                       hit_msk ? {28'h0000000, msk_ff} : RD_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Modem input pins pass two flip-flops.
  modem_sync #(.W(4), .INIT(4'hF)) u_sync_modem (
    .clk(clk),
    .rst_n(rst_n),
    .d({carrier_detect_n, ring_ind_n, dsr_n_pin, cts_n_pin}),
    .q(pins_sync)
  );

  // Receive pin passes two flip-flops.
  modem_sync #(.W(1), .INIT(1'b1)) u_sync_rx (
    .clk(clk),
    .rst_n(rst_n),
    .d(rx_pin),
    .q(rx_sync)
  );

  // The bus style strap is a pin too; a change reaches the interrupt pin
  // style two cycles later, which is harmless for a board strap.
  modem_sync #(.W(1), .INIT(1'b1)) u_sync_style (
    .clk(clk),
    .rst_n(rst_n),
    .d(bus16_mode),
    .q(bus16_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loopback routing.

  // In loopback, aux two feeds carrier detect, aux one ring, request feeds
  // clear-to-send and ready feeds data-set-ready, all inverted as pins would.
  wire [3:0] loop_status_n = ~{modem_control_reg_ff[CTRL_AUX_TWO],
                               modem_control_reg_ff[CTRL_AUX_ONE],
                               modem_control_reg_ff[CTRL_DTR],
                               modem_control_reg_ff[CTRL_RTS]};
  wire [3:0] nxt_status_n = loop_on ? loop_status_n : pins_sync;

  assign modem_status_n = nxt_status_n;
  assign uart_rx_data = loop_on ? uart_tx_data : rx_sync;
  assign tx_pin = loop_on ? 1'b1 : uart_tx_data;
  assign rts_n = loop_on ? 1'b1 : ~modem_control_reg_ff[CTRL_RTS];
  assign dtr_n = loop_on ? 1'b1 : ~modem_control_reg_ff[CTRL_DTR];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources and status.

  wire modem_chg = modem_prev_ff != nxt_status_n; // Any modem line changed.
  wire loop_chg = wr_ctrl && (wb_dat_i[CTRL_LOOP] != loop_on); // Loopback toggled.
  wire [3:0] raw_evt = {loop_chg, modem_chg, tx_event, rx_event}; // Source events.
  wire [3:0] gated_evt = raw_evt & int_enable_reg_ff;
  wire [3:0] nxt_sts = gated_evt | (rd_sts ? 4'h0 : sts_ff); // Set wins over clear.
  wire int_act = |(sts_ff & msk_ff); // Unmasked event pending.

  // Remember the modem status for change detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_prev_ff <= 4'hF;
    end else begin
      modem_prev_ff <= nxt_status_n;
    end
  end

  // Modem control register; clears to zero on reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_control_reg_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      modem_control_reg_ff <= wb_dat_i[7:0];
    end
  end

  // Enable, mask and status registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable_reg_ff <= ENA_RST;
      msk_ff <= MSK_RST;
      sts_ff <= 4'h0;
    end else begin
      if (wr_ena) begin
        int_enable_reg_ff <= wb_dat_i[3:0];
      end
      if (wr_msk) begin
        msk_ff <= wb_dat_i[3:0];
      end
      sts_ff <= nxt_sts;
    end
  end

  // Bus answer one cycle after the request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdat_ff <= RD_NONE;
    end else begin
      ack_ff <= req;
      rdat_ff <= rd ? rd_mux : RD_NONE;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq = int_act;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin style.

  wire style_open = !bus16_sync || modem_control_reg_ff[CTRL_INT_TYPE];
  wire open_drain = !bus16_sync; // Pulls low when active, 68 style.

  // Push-pull drives always; open-source drives only high when active;
  // open-drain drives only low when active (active-low in that style).
  assign int_o = open_drain ? 1'b0 : int_act;
  assign int_oe = !style_open ? 1'b1 : int_act;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_ctrl_write;
    wr_ctrl;
  endsequence

  // A control write that turns loopback on.
  sequence s_loop_enter;
    s_ctrl_write ##0 wb_dat_i[CTRL_LOOP];
  endsequence

  property p_reset_zero;
    @(posedge clk) $rose(rst_n) |-> modem_control_reg_ff == CTRL_RST;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset");

  property p_push_pull;
    @(posedge clk) disable iff (!rst_n)
      (bus16_sync && !modem_control_reg_ff[CTRL_INT_TYPE]) |-> (int_oe && int_o == irq);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull style wrong");

  property p_open_drain;
    @(posedge clk) disable iff (!rst_n)
      !bus16_sync |-> (!int_o && int_oe == irq);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain style wrong");

  property p_loop_cut;
    @(posedge clk) disable iff (!rst_n)
      modem_control_reg_ff[4] |-> (tx_pin && rts_n && dtr_n && uart_rx_data == uart_tx_data);
  endproperty
  a_loop_cut: assert property (p_loop_cut) else $error("loopback pins not cut");

  property p_loop_map;
    @(posedge clk) disable iff (!rst_n)
      modem_control_reg_ff[4] |->
        modem_status_n == ~{modem_control_reg_ff[3], modem_control_reg_ff[2],
                            modem_control_reg_ff[0], modem_control_reg_ff[1]};
  endproperty
  a_loop_map: assert property (p_loop_map) else $error("loopback status map wrong");

  property p_pins_drive;
    @(posedge clk) disable iff (!rst_n)
      !modem_control_reg_ff[4] |-> (rts_n == !modem_control_reg_ff[1])
        && (dtr_n == !modem_control_reg_ff[0]);
  endproperty
  a_pins_drive: assert property (p_pins_drive) else $error("rts or dtr wrong");

  property p_ctrl_update;
    @(posedge clk) disable iff (!rst_n)
      s_ctrl_write |=> modem_control_reg_ff == $past(wb_dat_i[7:0]);
  endproperty
  a_ctrl_update: assert property (p_ctrl_update) else $error("control write lost");

  property p_rx_event;
    @(posedge clk) disable iff (!rst_n)
      (rx_event && int_enable_reg_ff[0]) |=> sts_ff[0];
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("rx event lost");

  property p_gate;
    @(posedge clk) disable iff (!rst_n)
      (!int_enable_reg_ff[2] && !sts_ff[2] && !rd_sts) |=> !sts_ff[2];
  endproperty
  a_gate: assert property (p_gate) else $error("disabled source set status");

  property p_loop_modem_int;
    @(posedge clk) disable iff (!rst_n)
      (loop_on && $stable(loop_on) && int_enable_reg_ff[SRC_MODEM]
        && $changed(modem_control_reg_ff[3:0])) |=> sts_ff[SRC_MODEM];
  endproperty
  a_loop_modem_int: assert property (p_loop_modem_int) else $error("loop modem int lost");

  property p_loop_link;
    @(posedge clk) disable iff (!rst_n)
      (modem_control_reg_ff[4] && uart_tx_data) |-> uart_rx_data;
  endproperty
  a_loop_link: assert property (p_loop_link) else $error("loop data path broken");

  // Transmitter events keep raising status, in loopback as well.
  property p_tx_event;
    @(posedge clk) disable iff (!rst_n)
      (tx_event && int_enable_reg_ff[SRC_TX]) |=> sts_ff[SRC_TX];
  endproperty
  a_tx_event: assert property (p_tx_event) else $error("tx event lost");

  // Open-source style drives only while the interrupt is pending.
  property p_open_source;
    @(posedge clk) disable iff (!rst_n)
      (bus16_sync && modem_control_reg_ff[CTRL_INT_TYPE]) |-> (int_o == irq && int_oe == irq);
  endproperty
  a_open_source: assert property (p_open_source) else $error("open-source style wrong");

  // Outside loopback the pins reach the core untouched.
  property p_normal_route;
    @(posedge clk) disable iff (!rst_n)
      !loop_on |-> (modem_status_n == pins_sync && uart_rx_data == rx_sync
        && tx_pin == uart_tx_data);
  endproperty
  a_normal_route: assert property (p_normal_route) else $error("normal routing wrong");

  // Entering loopback parks the outputs at their idle level.
  property p_loop_enter;
    @(posedge clk) disable iff (!rst_n)
      s_loop_enter |=> (loop_on && tx_pin && rts_n && dtr_n);
  endproperty
  a_loop_enter: assert property (p_loop_enter) else $error("loopback entry wrong");

  // A pending status bit stays until a status read.
  property p_sticky;
    @(posedge clk) disable iff (!rst_n)
      (sts_ff[SRC_RX] && !rd_sts) |=> sts_ff[SRC_RX];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped");
endmodule

// ===== verilog/modem_sync.sv
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs come from outside the clk domain.
*/
module modem_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk, // Block clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] d, // Asynchronous inputs.
  output logic [W-1:0] q // Synchronised outputs.
);
  logic [W-1:0] meta_ff; // First stage, read only by the second.

  // Two stages clocked in series.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= INIT;
      q <= INIT;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
